//--- shared/sncap_defs.vh
`ifndef SNCAP_DEFS_VH
`define SNCAP_DEFS_VH
// register addresses on the serial register port
`define SC_A_CTRL   13'h101
`define SC_A_HOLD   13'h102
`define SC_A_LEN    13'h104
`define SC_A_SET0   13'h105
`define SC_A_SET1   13'h106
`define SC_A_RBREQ  13'h107
`define SC_A_STAT   13'h10a
`define SC_A_OFF0   13'h10f
`define SC_A_OFF1   13'h110
`define SC_A_PDIV   13'h111
`define SC_A_SDIV   13'h112
`define SC_A_BUFFER_SELF_TEST   13'h13a
// field positions
`define SC_CTRL_GO      0
`define SC_MODE_HI      3
`define SC_MODE_LO      2
`define SC_MODE_SINGLE  2'b00
`define SC_BUFFER_SELF_TEST_EN      0
`define SC_BUFFER_SELF_TEST_HI      4
`define SC_BUFFER_SELF_TEST_LO      1
`define SC_STAT_FULL    0
`define SC_STAT_EMPTY   1
// reset values
`define SC_DIV_RST      8'h04
`define SC_ZERO8        8'h00
// segment size as a shift count, flag timing in sampling clock cycles
`define SC_SEG_SHIFT    6
`define SC_EMPTY_LAT    15'd24
`define SC_FULL_LAT     15'd13
// self-test pattern codes
`define SC_PAT_INC      4'h0
`define SC_PAT_DEC      4'h1
`define SC_PAT_CHK_A    4'h2
`define SC_PAT_CHK_5    4'h3
`define SC_PAT_PN       4'h4
`define SC_PAT_PLUS1    4'h5
`define SC_PAT_MINUS1   4'h6
// self-test words
`define SC_W_A          12'haaa
`define SC_W_5          12'h555
`define SC_W_ONE        12'h001
`define SC_W_ALL        12'hfff
`define SC_W_ZERO       12'h000
`endif

//--- hdl/sncap_fifo_ctrl.v
// Notes on behaviour
// - capture length count is eight bits, 0..255
// - stored samples equal (count plus one) times 64
// - capture starts from trigger pin or register
// - pin trigger delayed by programmable hold-off counter
// - when stored, raise full, await readback request
// - after readback drains, go idle, await capture
// - capture from standby powers converter up first
// - after power-up wait settle count before storing
// - full and empty flags, mirrored in status
// - mode field 00 selects single capture
// - single mode: control bit zero starts capture
// - control bit zero: standby after readback drains
// - empty falls 24 cycles after trigger high
// - full rises samples plus 13 cycles after
// - new trigger during capture restarts filling
`include "sncap_defs.vh"
`default_nettype none
module sncap_fifo_ctrl (
    input  wire        clk,
    input  wire        reset,
    input  wire        capture_trigger,
    input  wire        readback_req,
    input  wire [11:0] adc_sample,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [12:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    output wire [7:0]  reg_rdata,
    output wire        full_flag,
    output wire        empty_flag,
    output wire        adc_standby,
    output wire [7:0]  parallel_readout_port_div,
    output wire [7:0]  serial_readout_port_div,
    output wire [11:0] rb_data,
    output wire        rb_valid,
    input  wire        rb_ready
);
    // one-hot sequencer states
    localparam [5:0] ST_IDLE   = 6'b000001;
    localparam [5:0] ST_HOLD   = 6'b000010;
    localparam [5:0] ST_SETTLE = 6'b000100;
    localparam [5:0] ST_LOAD   = 6'b001000;
    localparam [5:0] ST_WAITF  = 6'b010000;
    localparam [5:0] ST_DUMP   = 6'b100000;

    // stored word count for a length setting
    function [14:0] seg_samples;
        input [7:0] cnt;
        begin
            seg_samples = ({7'h00, cnt} + 15'd1) << `SC_SEG_SHIFT;
        end
    endfunction

    // next self-test word from the current one
    function [11:0] pat_next;
        input [3:0]  mode;
        input [11:0] cur;
        begin
            case (mode)
                `SC_PAT_INC:    pat_next = cur + `SC_W_ONE;
                `SC_PAT_DEC:    pat_next = cur - `SC_W_ONE;
                `SC_PAT_CHK_A,
                `SC_PAT_CHK_5:  pat_next = (cur == `SC_W_A) ? `SC_W_5 : `SC_W_A;
                `SC_PAT_PN:     pat_next = {cur[10:0], cur[11] ^ cur[10] ^ cur[9] ^ cur[3]};
                `SC_PAT_PLUS1:  pat_next = `SC_W_ONE;
                `SC_PAT_MINUS1: pat_next = `SC_W_ALL;
                default:        pat_next = `SC_W_ZERO;
            endcase
        end
    endfunction

    // first self-test word of a capture
    function [11:0] pat_seed;
        input [3:0] mode;
        begin
            case (mode)
                `SC_PAT_CHK_A:  pat_seed = `SC_W_A;
                `SC_PAT_CHK_5:  pat_seed = `SC_W_5;
                `SC_PAT_PN,
                `SC_PAT_PLUS1:  pat_seed = `SC_W_ONE;
                `SC_PAT_MINUS1: pat_seed = `SC_W_ALL;
                default:        pat_seed = `SC_W_ZERO;
            endcase
        end
    endfunction

    // stored words live in a plain array with no reset, so it maps to ram
    reg  [11:0] cap_mem [0:16383];
    reg  [11:0] mem_q_r;
    reg  [5:0]  state_r;
    reg         trig_m_r, trig_s_r;
    reg         rbq_m_r, rbq_s_r;
    reg  [7:0]  ctrl_r, hold_r, len_r, set0_r, set1_r;
    reg  [7:0]  off0_r, off1_r, pdiv_r, sdiv_r, buffer_self_test_r;
    reg  [7:0]  rdata_r;
    reg         full_r, empty_r, standby_r;
    reg  [7:0]  hcnt_r;
    reg  [15:0] scnt_r;
    reg  [14:0] since_r, wcnt_r, raddr_r;
    reg  [11:0] pat_r;
    reg         pend_r;
    // set from wake-up until the settle count has run out, so a retrigger keeps the settle
    reg         wake_r;
    reg  [11:0] buf_r [0:1];
    reg         bhead_r;
    reg  [1:0]  bcnt_r;

    // derived controls and strobes
    wire [14:0] nsamp    = seg_samples(len_r);
    wire [3:0]  pat_mode = buffer_self_test_r[`SC_BUFFER_SELF_TEST_HI:`SC_BUFFER_SELF_TEST_LO];
    wire        buffer_self_test_on  = buffer_self_test_r[`SC_BUFFER_SELF_TEST_EN];
    wire [14:0] rd_start = {1'b0, off1_r[5:0], off0_r};
    wire        cap_state = |(state_r & (ST_IDLE | ST_HOLD | ST_SETTLE | ST_LOAD));
    wire        single_md = (ctrl_r[`SC_MODE_HI:`SC_MODE_LO] == `SC_MODE_SINGLE);
    wire        reg_go   = reg_wr && (reg_addr == `SC_A_CTRL) && reg_wdata[`SC_CTRL_GO]
                           && (reg_wdata[`SC_MODE_HI:`SC_MODE_LO] == `SC_MODE_SINGLE);
    wire        pin_go   = trig_s_r && single_md;
    wire        rb_go    = rbq_s_r || (reg_wr && (reg_addr == `SC_A_RBREQ) && reg_wdata[0]);
    wire        mem_we   = (state_r == ST_LOAD) && (wcnt_r < nsamp) && !trig_s_r;
    wire [11:0] mem_wd   = buffer_self_test_on ? pat_r : adc_sample;
    wire        b_in_rdy = (bcnt_r != 2'd2);
    wire        b_pop    = rb_valid && rb_ready;
    wire        rd_issue = (state_r == ST_DUMP) && !pend_r && b_in_rdy && (raddr_r < nsamp);
    wire        drained  = (raddr_r >= nsamp) && !pend_r && (bcnt_r == 2'd0);

    // outputs come straight from flops; rb_valid from the buffer count, rb_data from the buffer entry at bhead_r
    assign full_flag   = full_r;
    assign empty_flag  = empty_r;
    assign adc_standby = standby_r;
    assign parallel_readout_port_div   = pdiv_r;
    assign serial_readout_port_div   = sdiv_r;
    assign reg_rdata   = rdata_r;
    assign rb_valid    = (bcnt_r != 2'd0);
    assign rb_data     = buf_r[bhead_r];

    // pins are asynchronous to the sampling clock: two flops before use
    always @(posedge clk) begin
        if (reset) begin
            trig_m_r <= 1'b0;
            trig_s_r <= 1'b0;
            rbq_m_r  <= 1'b0;
            rbq_s_r  <= 1'b0;
        end else begin
            trig_m_r <= capture_trigger;
            trig_s_r <= trig_m_r;
            rbq_m_r  <= readback_req;
            rbq_s_r  <= rbq_m_r;
        end
    end

    // register writes; the go bit is a command and also the standby choice
    always @(posedge clk) begin
        if (reset) begin
            ctrl_r <= `SC_ZERO8;
            hold_r <= `SC_ZERO8;
            len_r  <= `SC_ZERO8;
            set0_r <= `SC_ZERO8;
            set1_r <= `SC_ZERO8;
            off0_r <= `SC_ZERO8;
            off1_r <= `SC_ZERO8;
            pdiv_r <= `SC_DIV_RST;
            sdiv_r <= `SC_DIV_RST;
            buffer_self_test_r <= `SC_ZERO8;
        end else if (reg_wr) begin
            case (reg_addr)
                `SC_A_CTRL: ctrl_r <= reg_wdata;
                `SC_A_HOLD: hold_r <= reg_wdata;
                `SC_A_LEN:  len_r  <= reg_wdata;
                `SC_A_SET0: set0_r <= reg_wdata;
                `SC_A_SET1: set1_r <= reg_wdata;
                `SC_A_OFF0: off0_r <= reg_wdata;
                `SC_A_OFF1: off1_r <= {2'b00, reg_wdata[5:0]};
                `SC_A_PDIV: pdiv_r <= {3'b000, reg_wdata[4:0]};
                `SC_A_SDIV: sdiv_r <= {3'b000, reg_wdata[4:0]};
                `SC_A_BUFFER_SELF_TEST: buffer_self_test_r <= {3'b000, reg_wdata[4:0]};
                default:    ctrl_r <= ctrl_r;
            endcase
        end
    end

    // register reads; unmapped addresses answer zero
    always @(posedge clk) begin
        if (reset) begin
            rdata_r <= `SC_ZERO8;
        end else if (reg_rd) begin
            case (reg_addr)
                `SC_A_CTRL: rdata_r <= ctrl_r;
                `SC_A_HOLD: rdata_r <= hold_r;
                `SC_A_LEN:  rdata_r <= len_r;
                `SC_A_SET0: rdata_r <= set0_r;
                `SC_A_SET1: rdata_r <= set1_r;
                `SC_A_STAT: rdata_r <= {6'h00, empty_r, full_r};
                `SC_A_OFF0: rdata_r <= off0_r;
                `SC_A_OFF1: rdata_r <= off1_r;
                `SC_A_PDIV: rdata_r <= pdiv_r;
                `SC_A_SDIV: rdata_r <= sdiv_r;
                `SC_A_BUFFER_SELF_TEST: rdata_r <= buffer_self_test_r;
                default:    rdata_r <= `SC_ZERO8;
            endcase
        end
    end

    // capture store and registered read port, kept apart so it maps to ram
    always @(posedge clk) begin
        if (mem_we) begin
            cap_mem[wcnt_r[13:0]] <= mem_wd;
        end
        mem_q_r <= cap_mem[raddr_r[13:0]];
    end

    // capture and readback sequencer
    always @(posedge clk) begin
        if (reset) begin
            state_r   <= ST_IDLE;
            full_r    <= 1'b0;
            empty_r   <= 1'b1;
            standby_r <= 1'b0;
            hcnt_r    <= `SC_ZERO8;
            scnt_r    <= 16'h0000;
            since_r   <= 15'd0;
            wcnt_r    <= 15'd0;
            raddr_r   <= 15'd0;
            pat_r     <= `SC_W_ZERO;
            pend_r    <= 1'b0;
            wake_r    <= 1'b0;
        end else begin
            pend_r <= rd_issue;
            if (cap_state && (pin_go || reg_go)) begin
                // a trigger seen high restarts everything, so the flag
                // latencies count from the last cycle it was high
                full_r  <= 1'b0;
                empty_r <= 1'b1;
                wcnt_r  <= 15'd0;
                since_r <= 15'd0;
                pat_r   <= pat_seed(pat_mode);
                if (pin_go && (hold_r != `SC_ZERO8)) begin
                    state_r <= ST_HOLD;
                    hcnt_r  <= hold_r;
                end else if (standby_r || wake_r) begin
                    // a pin held high retriggers while waking: restart the settle, not skip it
                    state_r   <= ST_SETTLE;
                    standby_r <= 1'b0;
                    wake_r    <= 1'b1;
                    scnt_r    <= {set1_r, set0_r};
                end else begin
                    state_r <= ST_LOAD;
                end
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        state_r <= ST_IDLE;
                    end
                    ST_HOLD: begin
                        hcnt_r <= hcnt_r - 8'h01;
                        if (hcnt_r == 8'h01) begin
                            if (standby_r || wake_r) begin
                                state_r   <= ST_SETTLE;
                                standby_r <= 1'b0;
                                wake_r    <= 1'b1;
                                scnt_r    <= {set1_r, set0_r};
                            end else begin
                                state_r <= ST_LOAD;
                            end
                        end
                    end
                    ST_SETTLE: begin
                        // converter is powering up; nothing is stored yet
                        if (scnt_r == 16'h0000) begin
                            state_r <= ST_LOAD;
                            wake_r  <= 1'b0;
                        end else begin
                            scnt_r <= scnt_r - 16'h0001;
                        end
                    end
                    ST_LOAD: begin
                        // since_r counts from the first load cycle after the last trigger
                        since_r <= since_r + 15'd1;
                        if (mem_we) begin
                            wcnt_r <= wcnt_r + 15'd1;
                            pat_r  <= pat_next(pat_mode, pat_r);
                        end
                        if (since_r == `SC_EMPTY_LAT - 15'd1) begin
                            empty_r <= 1'b0;
                        end
                        if (since_r == nsamp + `SC_FULL_LAT - 15'd1) begin
                            full_r  <= 1'b1;
                            state_r <= ST_WAITF;
                        end
                    end
                    ST_WAITF: begin
                        // retriggers are refused here until readback drains
                        if (rb_go) begin
                            state_r <= ST_DUMP;
                            raddr_r <= rd_start;
                        end
                    end
                    ST_DUMP: begin
                        // at most one read per two cycles: pend_r blocks the next issue
                        if (rd_issue) begin
                            raddr_r <= raddr_r + 15'd1;
                        end
                        if (drained) begin
                            state_r   <= ST_IDLE;
                            full_r    <= 1'b0;
                            empty_r   <= 1'b1;
                            standby_r <= ctrl_r[`SC_CTRL_GO];
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // two-entry output buffer; a read is issued only with a free slot,
    // so the word in flight from the ram always has a place to land
    always @(posedge clk) begin
        if (reset) begin
            bhead_r <= 1'b0;
            bcnt_r  <= 2'd0;
        end else begin
            if (pend_r) begin
                buf_r[bhead_r ^ bcnt_r[0]] <= mem_q_r;
            end
            if (b_pop) begin
                bhead_r <= ~bhead_r;
            end
            case ({pend_r, b_pop})
                2'b10:   bcnt_r <= bcnt_r + 2'd1;
                2'b01:   bcnt_r <= bcnt_r - 2'd1;
                default: bcnt_r <= bcnt_r;
            endcase
        end
    end
endmodule // sncap_fifo_ctrl
`default_nettype wire

//--- bench/sncap_checker.sv
`include "sncap_defs.vh"
`default_nettype none
module sncap_checker (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        capture_trigger,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [12:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        full_flag,
    input wire logic        empty_flag,
    input wire logic        adc_standby,
    input wire logic [7:0]  parallel_readout_port_div,
    input wire logic [7:0]  serial_readout_port_div,
    input wire logic [11:0] rb_data,
    input wire logic        rb_valid,
    input wire logic        rb_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  len_r;
    logic [14:0] cnt_r;
    logic        arm_r;
    wire  [14:0] n_smp = ({7'h00, len_r} + 15'h0001) << `SC_SEG_SHIFT;
    wire         go = reg_wr && reg_addr == `SC_A_CTRL && reg_wdata[0] && !reg_wdata[3] && !reg_wdata[2];
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // count from a register start while empty, not full and awake; pin starts are not timed here, so they disarm
    always_ff @(posedge clk) begin
        if (reset) begin
            len_r <= 8'h00;
            arm_r <= 1'b0;
            cnt_r <= 15'h0000;
        end else begin
            if (reg_wr && reg_addr == `SC_A_LEN) len_r <= reg_wdata;
            if (go) arm_r <= empty_flag && !full_flag && !adc_standby;
            else if (capture_trigger || full_flag) arm_r <= 1'b0;
            cnt_r <= go ? 15'h0001 : cnt_r + 15'h0001;
        end
    end
    // empty leaves cycles 23 to 25 unchecked, full only cycle n_smp+13: the note leaves the sampling edge of a flag open
    rst_vals_a: assert property (disable iff (1'b0) $fell(reset) |-> empty_flag && !full_flag
        && !adc_standby && !rb_valid && parallel_readout_port_div == 8'h04 && serial_readout_port_div == 8'h04)
        else $error("bad values after reset");
    stat_mirror_a: assert property (reg_rd && reg_addr == `SC_A_STAT |=>
        reg_rdata == {6'h00, $past(empty_flag), $past(full_flag)}) else $error("status mismatch");
    flag_excl_a: assert property (full_flag |-> !empty_flag) else $error("full and empty");
    full_early_a: assert property (arm_r && cnt_r <= n_smp + 15'd12 |-> !full_flag)
        else $error("full too early");
    full_time_a: assert property (arm_r && cnt_r == n_smp + 15'd14 |-> full_flag)
        else $error("full too late");
    empty_time_a: assert property (arm_r && cnt_r == 15'd26 |-> !empty_flag)
        else $error("empty not low");
    empty_early_a: assert property (arm_r && cnt_r <= 15'd22 |-> empty_flag)
        else $error("empty low early");
    rb_in_full_a: assert property (rb_valid |-> full_flag) else $error("word outside wait");
    rb_hold_a: assert property (rb_valid && !rb_ready |=> rb_valid && $stable(rb_data))
        else $error("word lost in stall");
    idle_after_a: assert property ($fell(full_flag) |-> $rose(empty_flag) && !rb_valid)
        else $error("no idle after readback");
    full_c: cover property ($rose(full_flag));
    stall_c: cover property (rb_valid && !rb_ready ##1 rb_valid && rb_ready);
    wake_c: cover property ($fell(adc_standby));
endmodule // sncap_checker
bind sncap_fifo_ctrl sncap_checker u_chk (.clk(clk), .reset(reset),
    .capture_trigger(capture_trigger), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .full_flag(full_flag), .empty_flag(empty_flag),
    .adc_standby(adc_standby), .parallel_readout_port_div(parallel_readout_port_div), .serial_readout_port_div(serial_readout_port_div), .rb_data(rb_data),
    .rb_valid(rb_valid), .rb_ready(rb_ready));
`default_nettype wire

//--- bench/sncap_host.sv
`default_nettype none
module sncap_host (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        full_flag,
    input  wire logic        empty_flag,
    input  wire logic [11:0] rb_data,
    input  wire logic        rb_valid,
    input  wire logic [11:0] first_word,
    input  wire logic        hold,
    output var  logic        readback_req,
    output wire logic        rb_ready,
    output var  logic [15:0] words,
    output var  logic [15:0] bad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_r;
    // stalls one cycle in four, and fully while hold is up
    assign rb_ready = !hold && ph_r != 2'd0;
    // request only once full, keep it up until the buffer is empty again
    always @(posedge clk) begin
        ph_r <= reset ? 2'd0 : ph_r + 2'd1;
        if (reset) begin
            readback_req <= 1'b0;
            words <= 16'h0000;
            bad <= 16'h0000;
        end else if (!readback_req && full_flag && !empty_flag) begin
            readback_req <= 1'b1;
            words <= 16'h0000;
        end else begin
            if (readback_req && empty_flag) readback_req <= 1'b0;
            if (rb_valid && rb_ready) begin
                if (rb_data !== first_word + words[11:0]) bad <= bad + 16'h0001;
                words <= words + 16'h0001;
            end
        end
    end
endmodule // sncap_host
`default_nettype wire

//--- bench/tb.sv
`include "sncap_defs.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, reset = 1'b1, capture_trigger = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [12:0] reg_addr = 13'h0000;
    logic [7:0]  reg_wdata = 8'h00;
    logic [11:0] adc_sample = 12'h000, first_word = 12'h000;
    logic        hold = 1'b1;
    wire  [7:0]  reg_rdata, parallel_readout_port_div, serial_readout_port_div;
    wire  [11:0] rb_data;
    wire  [15:0] words, bad;
    wire         full_flag, empty_flag, adc_standby, rb_valid, rb_ready, readback_req;
    int n_fail = 0, check_count = 0, cyc = 0, n, i;
    logic [12:0] ra [6] = '{`SC_A_PDIV, `SC_A_SDIV, `SC_A_OFF1, `SC_A_BUFFER_SELF_TEST, `SC_A_STAT, 13'h1ff};
    logic [7:0]  rv [6] = '{8'h04, 8'h04, 8'h00, 8'h00, 8'h02, 8'h00};
    sncap_fifo_ctrl dut (.clk(clk), .reset(reset), .capture_trigger(capture_trigger),
        .readback_req(readback_req), .adc_sample(adc_sample), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .full_flag(full_flag),
        .empty_flag(empty_flag), .adc_standby(adc_standby), .parallel_readout_port_div(parallel_readout_port_div),
        .serial_readout_port_div(serial_readout_port_div), .rb_data(rb_data), .rb_valid(rb_valid), .rb_ready(rb_ready));
    sncap_host u_host (.clk(clk), .reset(reset), .full_flag(full_flag), .empty_flag(empty_flag),
        .rb_data(rb_data), .rb_valid(rb_valid), .first_word(first_word), .hold(hold),
        .readback_req(readback_req), .rb_ready(rb_ready), .words(words), .bad(bad));
    always #10 clk = ~clk;
    // moving samples, and a ceiling well above the longest expected run
    always @(posedge clk) begin
        adc_sample <= adc_sample + 12'h001;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (n_fail == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge clk);
        #2 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #2 reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [12:0] a, input logic [7:0] exp);
        @(posedge clk);
        #2 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #2 reg_rd = 1'b0;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask
    // sel 0 full, 1 empty, 2 standby; bounded so a stuck flag shows as a mismatch
    task automatic wait_on(input int sel, input logic v);
        n = 0;
        while ((sel == 0 ? full_flag : sel == 1 ? empty_flag : adc_standby) !== v && n < 900) begin
            @(posedge clk);
            #2 n++;
        end
        chk(16'(n < 900), 16'h0001);
    endtask
    task automatic pulse_pin();
        @(posedge clk);
        #2 capture_trigger = 1'b1;
        repeat (3) @(posedge clk);
        #2 capture_trigger = 1'b0;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #2 reset = 1'b0;
        for (i = 0; i < 6; i++) rd(ra[i], rv[i]);
        wr(`SC_A_PDIV, 8'hff);
        rd(`SC_A_PDIV, 8'h1f);
        // register start, ramp pattern, offset readback, restart mid-fill, stalled consumer
        wr(`SC_A_LEN, 8'h00);
        wr(`SC_A_BUFFER_SELF_TEST, 8'h01);
        wr(`SC_A_OFF0, 8'h10);
        first_word = 12'h010;
        wr(`SC_A_CTRL, 8'h01);
        repeat (10) @(posedge clk);
        wr(`SC_A_CTRL, 8'h01);
        repeat (70) @(posedge clk);
        #2 chk(16'(full_flag), 16'h0000);
        wait_on(0, 1'b1);
        rd(`SC_A_STAT, 8'h01);
        repeat (20) @(posedge clk);
        #2 chk(16'({rb_valid, full_flag}), 16'h0003);
        hold = 1'b0;
        wait_on(1, 1'b1);
        chk(words, 16'd48);
        chk(16'({full_flag, adc_standby}), 16'h0001);
        // continuous mode code: the pin must not start a capture
        wr(`SC_A_CTRL, 8'h04);
        pulse_pin();
        repeat (200) @(posedge clk);
        #2 chk(16'({full_flag, empty_flag}), 16'h0001);
        // pin start from standby with settle delay and two segments
        wr(`SC_A_CTRL, 8'h00);
        wr(`SC_A_SET0, 8'h40);
        wr(`SC_A_SET1, 8'h00);
        wr(`SC_A_LEN, 8'h01);
        wr(`SC_A_OFF0, 8'h00);
        first_word = 12'h000;
        pulse_pin();
        chk(16'(adc_standby), 16'h0000);
        wait_on(0, 1'b1);
        chk(16'(n >= 200 && n <= 212), 16'h0001);
        wait_on(1, 1'b1);
        chk(words, 16'd128);
        chk(bad, 16'h0000);
        chk(16'(adc_standby), 16'h0000);
        // pin start through a 32-cycle hold-off, converter awake, one segment
        wr(`SC_A_HOLD, 8'h20);
        wr(`SC_A_LEN, 8'h00);
        pulse_pin();
        wait_on(0, 1'b1);
        chk(16'(n >= 108 && n <= 114), 16'h0001);
        wait_on(1, 1'b1);
        chk(words, 16'd64);
        chk(bad, 16'h0000);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
